// ### core/placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### core/watchdog_sleep_wake.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_sleep_wake #(
  parameter int PIN_COUNT = 8,
  parameter int BASE_W = 16,
  parameter logic [15:0] WDT_BASE_TICKS = 16'(wdt_pkg::WDT_BASE_DEFAULT)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Asynchronous pins
  input wire logic wdt_osc_in,
  input wire logic master_clear_pin_n,
  // Fuses
  input wire logic [13:0] fuse_word,
  // Register port
  input wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wdt_pkg::DATA_W-1:0] reg_rdata,
  // Core side
  input wire logic kick_instruction,
  input wire logic sleep_instruction,
  input wire logic global_irq_enable,
  input wire wdt_pkg::irq_src_s irq_src,
  input wire logic timer0_tick,
  output logic timer0_inc,
  output logic device_reset,
  output logic core_halt,
  output logic osc_driver_on,
  output logic prefetch_next,
  output logic resume,
  output logic take_vector,
  output logic [12:0] vector_addr,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  // I/O pins
  input wire logic [PIN_COUNT-1:0] port_out,
  input wire logic [PIN_COUNT-1:0] port_oe,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe
);

  // Low bits of the shared divider that must all be set for one output
  function automatic logic [7:0] ratio_mask(input logic [2:0] ps, input logic timer_side);
    logic [7:0] one;
    one = timer_side ? 8'h02 : 8'h01;
    return (one << ps) - 8'h01;
  endfunction : ratio_mask

  wdt_pkg::power_state_e state_q;
  logic osc_meta_q, osc_sync_q, osc_prev_q;
  logic master_clear_pin_meta_q, master_clear_pin_sync_q;
  logic [13:0] config_q;
  logic [7:0] option_q;
  logic [BASE_W-1:0] base_q;
  logic [7:0] post_q;
  logic [15:0] ost_q;
  logic to_q, pd_q;
  logic ext_en_latched_q;
  logic irq_wake_q;
  logic [wdt_pkg::DATA_W-1:0] rdata_q;
  logic timer0_inc_q, device_reset_q, core_halt_q, osc_on_q;
  logic prefetch_q, resume_q, vector_q;
  logic [PIN_COUNT-1:0] pin_out_q, pin_oe_q;

  logic osc_tick, master_clear_pin_active, fuse_en, post_sel;
  logic [2:0] ps;
  logic base_wrap, timeout, pending, periph_wake, irq_wake;
  logic sleep_nop, sleep_take, kick, wake_any, ost_done, osc_rc;

  // Two-flop synchronisers for the watchdog oscillator and the clear pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
      master_clear_pin_meta_q <= 1'b1;
      master_clear_pin_sync_q <= 1'b1;
    end else begin
      osc_meta_q <= wdt_osc_in;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
      master_clear_pin_meta_q <= master_clear_pin_n;
      master_clear_pin_sync_q <= master_clear_pin_meta_q;
    end
  end

  // Fuses are caught while reset is held, so later pin changes do nothing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      config_q <= fuse_word;
    end
  end

  assign osc_tick = osc_sync_q & ~osc_prev_q;
  assign master_clear_pin_active = ~master_clear_pin_sync_q;
  assign fuse_en = config_q[wdt_pkg::FUSE_EN_BIT];
  assign osc_rc = (config_q[wdt_pkg::FOSC_MSB:0] == wdt_pkg::OSC_MODE_RC);
  assign post_sel = option_q[wdt_pkg::ASSIGN_BIT];
  assign ps = option_q[wdt_pkg::PS_MSB:0];

  // Base period wraps, then the divider stretches it when assigned
  assign base_wrap = osc_tick & fuse_en & (base_q == BASE_W'(WDT_BASE_TICKS - 16'h0001));
  assign timeout = base_wrap &
                   (~post_sel | ((post_q & ratio_mask(ps, 1'b0)) == ratio_mask(ps, 1'b0)));

  // Enabled flags, peripherals only in their sleep-capable modes; global enable deliberately plays no part
  assign periph_wake = (irq_src.timer_one_flag & irq_src.timer_one_enable & irq_src.timer_one_async) |
                       (irq_src.capture_flag & irq_src.capture_enable & irq_src.capture_mode) |
                       (irq_src.special_event_flag & irq_src.special_event_enable &
                        irq_src.timer_one_async & irq_src.timer_one_ext_clk);
  assign pending = (irq_src.ext_edge_flag & irq_src.ext_edge_irq_enable) |
                   (irq_src.port_change_flag & irq_src.port_change_enable) | periph_wake;
  assign irq_wake = (irq_src.ext_edge_flag & irq_src.ext_edge_irq_enable & ext_en_latched_q) |
                    (irq_src.port_change_flag & irq_src.port_change_enable) |
                    periph_wake;

  assign sleep_nop = sleep_instruction & (state_q == wdt_pkg::ST_RUN) &
                     ~global_irq_enable & pending;
  assign sleep_take = sleep_instruction & (state_q == wdt_pkg::ST_RUN) & ~sleep_nop;
  assign kick = kick_instruction & (state_q == wdt_pkg::ST_RUN);
  assign wake_any = (state_q == wdt_pkg::ST_SLEEP) & (timeout | irq_wake);
  assign ost_done = (ost_q == 16'(wdt_pkg::OST_CYCLES - 1));

  // Option register; rst and the master clear restore it, a watchdog time-out reset does not
  always_ff @(posedge core_clk) begin
    if (rst || master_clear_pin_active) begin
      option_q <= wdt_pkg::OPTION_RESET;
    end else if (reg_wr && reg_addr == wdt_pkg::OPTION_ADDR) begin
      option_q <= reg_wdata;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        wdt_pkg::OPTION_ADDR: rdata_q <= {8'h00, option_q};
        wdt_pkg::CONFIG_ADDR: rdata_q <= {2'h0, config_q};
        wdt_pkg::STATUS_ADDR: rdata_q <= 16'(({15'h0000, to_q} << wdt_pkg::TIMEOUT_FLAG_BIT) |
                                             ({15'h0000, pd_q} << wdt_pkg::PWRDN_FLAG_BIT));
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // Base counter keeps running in every power state
  always_ff @(posedge core_clk) begin
    if (rst || master_clear_pin_active || !fuse_en) begin
      base_q <= '0;
    end else if (kick || sleep_take) begin
      base_q <= '0;
    end else if (base_wrap) begin
      base_q <= '0;
    end else if (osc_tick) begin
      base_q <= base_q + BASE_W'(1);
    end
  end

  // Shared divider: watchdog postscaler or timer0 prescaler
  always_ff @(posedge core_clk) begin
    if (rst || master_clear_pin_active) begin
      post_q <= '0;
    end else if ((kick || sleep_take) && post_sel) begin
      post_q <= '0;
    end else if (post_sel && base_wrap) begin
      post_q <= post_q + 8'h01;
    end else if (!post_sel && timer0_tick) begin
      post_q <= post_q + 8'h01;
    end
  end

  // Timer0 increments, divided only while the divider is its own
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer0_inc_q <= 1'b0;
    end else begin
      timer0_inc_q <= timer0_tick &
                      (post_sel | ((post_q & ratio_mask(ps, 1'b1)) == ratio_mask(ps, 1'b1)));
    end
  end

  // Status flags; a time-out beats a same-cycle kick so it is never lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (master_clear_pin_active) begin
      if (state_q != wdt_pkg::ST_RUN) begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end
    end else if (timeout) begin
      to_q <= 1'b0;
      if (state_q == wdt_pkg::ST_RUN) begin
        pd_q <= 1'b1;
      end
    end else if (kick) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (sleep_take) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
  end

  // Power state machine
  always_ff @(posedge core_clk) begin
    if (rst || master_clear_pin_active) begin
      state_q <= wdt_pkg::ST_RUN;
    end else begin
      case (state_q)
        wdt_pkg::ST_RUN: begin
          if (sleep_take) begin
            state_q <= wdt_pkg::ST_SLEEP;
          end
        end
        wdt_pkg::ST_SLEEP: begin
          if (wake_any) begin
            state_q <= osc_rc ? wdt_pkg::ST_RUN : wdt_pkg::ST_START;
          end
        end
        wdt_pkg::ST_START: begin
          if (ost_done) begin
            state_q <= wdt_pkg::ST_RUN;
          end
        end
        default: state_q <= wdt_pkg::ST_RUN;
      endcase
    end
  end

  // Start-up wait counter, restarted on every wake into ST_START
  always_ff @(posedge core_clk) begin
    if (rst || state_q != wdt_pkg::ST_START) begin
      ost_q <= '0;
    end else if (!ost_done) begin
      ost_q <= ost_q + 16'h0001;
    end
  end

  // Edge enable must already be set when sleep takes effect
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_en_latched_q <= 1'b0;
    end else if (sleep_take) begin
      ext_en_latched_q <= irq_src.ext_edge_irq_enable;
    end
  end

  // Remember an interrupt wake so the vector decision waits for start-up
  always_ff @(posedge core_clk) begin
    if (rst || master_clear_pin_active) begin
      irq_wake_q <= 1'b0;
    end else if (wake_any) begin
      irq_wake_q <= irq_wake & ~timeout;
    end
  end

  // Core controls; the resume pulse lets the prefetched word run first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      device_reset_q <= 1'b1;
      core_halt_q <= 1'b0;
      osc_on_q <= 1'b1;
      prefetch_q <= 1'b0;
      resume_q <= 1'b0;
      vector_q <= 1'b0;
    end else begin
      device_reset_q <= master_clear_pin_active | (timeout & (state_q == wdt_pkg::ST_RUN));
      core_halt_q <= ~master_clear_pin_active & (sleep_take | (state_q != wdt_pkg::ST_RUN &&
                     !(wake_any && osc_rc) && !(state_q == wdt_pkg::ST_START && ost_done)));
      osc_on_q <= master_clear_pin_active | ~(sleep_take | (state_q == wdt_pkg::ST_SLEEP && !wake_any));
      prefetch_q <= sleep_instruction & (state_q == wdt_pkg::ST_RUN);
      resume_q <= ~master_clear_pin_active & ((wake_any & osc_rc) |
                  ((state_q == wdt_pkg::ST_START) & ost_done));
      vector_q <= ~master_clear_pin_active & global_irq_enable &
                  (((wake_any & osc_rc) & irq_wake & ~timeout) |
                   ((state_q == wdt_pkg::ST_START) & ost_done & irq_wake_q));
    end
  end

  // Pins follow the port logic only while running
  always_ff @(posedge core_clk) begin
    if (rst || master_clear_pin_active) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
    end else if (state_q == wdt_pkg::ST_RUN && !sleep_take) begin
      pin_out_q <= port_out;
      pin_oe_q <= port_oe;
    end
  end

  assign reg_rdata = rdata_q;
  assign timer0_inc = timer0_inc_q;
  assign device_reset = device_reset_q;
  assign core_halt = core_halt_q;
  assign osc_driver_on = osc_on_q;
  assign prefetch_next = prefetch_q;
  assign resume = resume_q;
  assign take_vector = vector_q;
  assign vector_addr = wdt_pkg::IRQ_VECTOR;
  assign timeout_flag_n = to_q;
  assign powerdown_flag_n = pd_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

  fuse_off_a: assert property (@(posedge core_clk) disable iff (rst)
    !fuse_en |=> base_q == '0 && !timeout) else $error("watchdog ran with fuse off");

  run_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    timeout && state_q == wdt_pkg::ST_RUN && !master_clear_pin_active |=> device_reset_q && !to_q && pd_q)
    else $error("run time-out did not reset");

  sleep_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    timeout && state_q == wdt_pkg::ST_SLEEP && !master_clear_pin_active |=>
    !device_reset_q && state_q != wdt_pkg::ST_SLEEP && !to_q && !pd_q)
    else $error("sleep time-out did not wake");

  kick_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    kick && !timeout && !master_clear_pin_active |=> base_q == '0 && (!post_sel || post_q == 8'h00) && to_q)
    else $error("kick left watchdog counting");

  sleep_entry_a: assert property (@(posedge core_clk) disable iff (rst)
    sleep_take && !timeout && !master_clear_pin_active |=>
    state_q == wdt_pkg::ST_SLEEP && !pd_q && to_q && base_q == '0 ##1
    (!osc_on_q || state_q != wdt_pkg::ST_SLEEP))
    else $error("sleep entry incomplete");

  sleep_nop_a: assert property (@(posedge core_clk) disable iff (rst)
    sleep_nop && !master_clear_pin_active && !timeout && !kick_instruction |=>
    state_q == wdt_pkg::ST_RUN && $stable(pd_q) && $stable(to_q))
    else $error("no-op sleep changed state");

  pins_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    state_q == wdt_pkg::ST_SLEEP && !master_clear_pin_active |=> $stable(pin_out_q) && $stable(pin_oe_q))
    else $error("pins moved while asleep");

  start_wait_a: assert property (@(posedge core_clk) disable iff (rst || master_clear_pin_active)
    $rose(state_q == wdt_pkg::ST_START) |-> !resume_q [*8])
    else $error("resumed before start-up wait");

  rc_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_any && osc_rc && !master_clear_pin_active |=> resume_q && state_q == wdt_pkg::ST_RUN)
    else $error("RC wake did not resume at once");

  vector_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    take_vector |-> resume && $past(global_irq_enable))
    else $error("vector taken without resume or enable");

endmodule : watchdog_sleep_wake

`default_nettype wire

// ### core/wdt_pkg.sv
package wdt_pkg;

  // Register port geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam logic [13:0] STATUS_ADDR = 14'h0003;
  localparam logic [13:0] OPTION_ADDR = 14'h0081;
  localparam logic [13:0] CONFIG_ADDR = 14'h2007;

  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'hff;

  // Field positions
  localparam int TIMEOUT_FLAG_BIT = 4;
  localparam int PWRDN_FLAG_BIT = 3;
  localparam int ASSIGN_BIT = 3;
  localparam int PS_MSB = 2;
  localparam int FUSE_EN_BIT = 2;
  localparam int FOSC_MSB = 1;

  // Oscillator select code that needs no start-up wait
  localparam logic [1:0] OSC_MODE_RC = 2'h3;

  // Interrupt vector taken after an interrupt wake with global enable set
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Start-up wait: 1024 oscillator periods, the oscillator being core_clk
  localparam int CLK_PERIOD_NS = 100;
  localparam int TOSC_NS = 100;
  localparam int OST_TOSC = 1024;
  localparam int OST_CYCLES = (OST_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default base watchdog period in watchdog oscillator ticks
  localparam int WDT_BASE_DEFAULT = 256;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10
  } power_state_e;

  // Interrupt flags, enables and modes from the core's interrupt logic
  typedef struct packed {
    logic ext_edge_flag;
    logic ext_edge_irq_enable;
    logic port_change_flag;
    logic port_change_enable;
    logic timer_one_flag;
    logic timer_one_enable;
    logic timer_one_async;
    logic timer_one_ext_clk;
    logic capture_flag;
    logic capture_enable;
    logic capture_mode;
    logic special_event_flag;
    logic special_event_enable;
  } irq_src_s;

endpackage : wdt_pkg

// ### sim/core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Requests from the bench program
  input wire logic do_kick,
  input wire logic do_sleep,
  // Device status
  input wire logic core_halt,
  input wire logic device_reset,
  // Instruction pulses
  output logic kick_instruction,
  output logic sleep_instruction
);
  logic sleep_pend_q;

  // Issue instruction pulses; a halted or reset core executes nothing
  always_ff @(posedge core_clk) begin
    if (rst || device_reset) begin
      kick_instruction <= 1'b0;
      sleep_instruction <= 1'b0;
      sleep_pend_q <= 1'b0;
    end else begin
      kick_instruction <= (do_kick || do_sleep) && !core_halt; // Kick just before sleep
      sleep_instruction <= sleep_pend_q && !core_halt;
      sleep_pend_q <= do_sleep && !core_halt;
    end
  end
endmodule : core_model

`default_nettype wire

// ### sim/watchdog_sleep_wake_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_sleep_wake_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, wdt_osc_in = 1'b0, master_clear_pin_n = 1'b1;
  logic [13:0] fuse_word = 14'h0003, reg_addr = 14'h0000;
  logic [7:0] reg_wdata = 8'h00, port_out = 8'h00, port_oe = 8'h00, pin_out, pin_oe, v;
  logic reg_wr = 1'b0, reg_rd = 1'b0, global_irq_enable = 1'b0, timer0_tick = 1'b0;
  logic do_kick = 1'b0, do_sleep = 1'b0, kick_instruction, sleep_instruction;
  logic [15:0] reg_rdata, held;
  logic timer0_inc, device_reset, core_halt, osc_driver_on, prefetch_next, resume;
  logic take_vector, timeout_flag_n, powerdown_flag_n, vec_seen;
  logic [12:0] vector_addr;
  wdt_pkg::irq_src_s irq_src = '0;
  int error_cnt = 0, checks_done = 0, cyc_cnt = 0, rst_cnt = 0, inc_cnt = 0, pf_cnt = 0;
  int r0, n;

  // 10 MHz core clock; watchdog oscillator runs free and unrelated
  always #50 core_clk = ~core_clk;
  always #353 wdt_osc_in = ~wdt_osc_in;

  watchdog_sleep_wake #(.WDT_BASE_TICKS(16'h0004)) i_watchdog_sleep_wake (
    .core_clk(core_clk), .rst(rst), .wdt_osc_in(wdt_osc_in),
    .master_clear_pin_n(master_clear_pin_n), .fuse_word(fuse_word), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .kick_instruction(kick_instruction), .sleep_instruction(sleep_instruction),
    .global_irq_enable(global_irq_enable), .irq_src(irq_src), .timer0_tick(timer0_tick),
    .timer0_inc(timer0_inc), .device_reset(device_reset), .core_halt(core_halt),
    .osc_driver_on(osc_driver_on), .prefetch_next(prefetch_next), .resume(resume),
    .take_vector(take_vector), .vector_addr(vector_addr), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .port_out(port_out), .port_oe(port_oe),
    .pin_out(pin_out), .pin_oe(pin_oe));

  core_model i_core_model (
    .core_clk(core_clk), .rst(rst), .do_kick(do_kick), .do_sleep(do_sleep),
    .core_halt(core_halt), .device_reset(device_reset),
    .kick_instruction(kick_instruction), .sleep_instruction(sleep_instruction));

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Event counters and the hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (!rst && device_reset === 1'b1) rst_cnt++;
    if (timer0_inc === 1'b1) inc_cnt++;
    if (prefetch_next === 1'b1) pf_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Ends just after an edge so registered outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read strobe
  task automatic rchk(input string nm, input logic [13:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
  endtask : rchk

  task automatic await_pulse(input bit on_reset, input int lim, output int k);
    k = 0;
    while (k < lim && ((on_reset ? device_reset : resume) !== 1'b1)) begin
      @(posedge core_clk);
      #1 k++;
    end
    // Vector pulse stands beside resume, so catch it in the same cycle
    vec_seen = take_vector;
  endtask : await_pulse

  task automatic pulse_cmd(input bit sleep);
    @(posedge core_clk);
    if (sleep) do_sleep <= 1'b1;
    else do_kick <= 1'b1;
    @(posedge core_clk);
    do_sleep <= 1'b0;
    do_kick <= 1'b0;
    cyc(4);
  endtask : pulse_cmd

  task automatic do_reset(input logic [13:0] f);
    @(posedge core_clk);
    rst <= 1'b1;
    fuse_word <= f;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    cyc(2);
  endtask : do_reset

  initial begin
    void'($urandom(32'h79ca929c));
    do_reset(14'h0003);
    // Reset values and register access kinds
    rchk("option reset", wdt_pkg::OPTION_ADDR, 16'h00ff);
    rchk("status reset", wdt_pkg::STATUS_ADDR, 16'h0018);
    rchk("config", wdt_pkg::CONFIG_ADDR, 16'h0003);
    rchk("unmapped", 14'h0100, 16'h0000);
    wr(wdt_pkg::STATUS_ADDR, 8'h00);
    rchk("status ro", wdt_pkg::STATUS_ADDR, 16'h0018);
    // Scaler on timer0 with ratio 1 divides by four
    wr(wdt_pkg::OPTION_ADDR, 8'h01);
    r0 = inc_cnt;
    repeat (16) begin
      @(posedge core_clk);
      timer0_tick <= 1'b1;
      @(posedge core_clk);
      timer0_tick <= 1'b0;
    end
    cyc(4);
    chk("timer0 incs", 16'h0004, 16'(inc_cnt - r0));
    // Fuse off: no time-out however long
    r0 = rst_cnt;
    cyc(300);
    chk("fuse off", 16'h0001, 16'({rst_cnt == r0, timeout_flag_n} == 2'b11));
    repeat (4) begin
      v = 8'($urandom);
      wr(wdt_pkg::OPTION_ADDR, v);
      rchk("option rw", wdt_pkg::OPTION_ADDR, {8'h00, v});
    end
    // Watchdog armed, RC mode, shortest period
    do_reset(14'h0007);
    wr(wdt_pkg::OPTION_ADDR, 8'h08);
    await_pulse(1'b1, 300, n);
    chk("run timeout", 16'h0001, 16'(n < 300));
    cyc(1);
    chk("reset pulse", 16'h0000, 16'(device_reset));
    rchk("status timeout", wdt_pkg::STATUS_ADDR, 16'h0008);
    wr(wdt_pkg::OPTION_ADDR, 8'h08);
    r0 = rst_cnt;
    repeat (20) begin
      pulse_cmd(1'b0);
      cyc(8);
    end
    chk("kicks hold", 16'h0000, 16'(rst_cnt - r0));
    rchk("assign kept", wdt_pkg::OPTION_ADDR, 16'h0008);
    // Pending enabled interrupt with globals off: sleep acts as no-op
    @(posedge core_clk);
    irq_src.port_change_flag <= 1'b1;
    irq_src.port_change_enable <= 1'b1;
    r0 = pf_cnt;
    pulse_cmd(1'b1);
    chk("noop halt", 16'h0001, 16'({core_halt, powerdown_flag_n} == 2'b01));
    chk("prefetch", 16'h0001, 16'(pf_cnt - r0));
    // Real sleep with long period; pins must freeze
    @(posedge core_clk);
    irq_src <= '0;
    port_out <= 8'($urandom);
    port_oe <= 8'($urandom);
    wr(wdt_pkg::OPTION_ADDR, 8'h0f);
    cyc(2);
    pulse_cmd(1'b1);
    chk("sleep state", 16'h0009,
        16'({core_halt, osc_driver_on, powerdown_flag_n, timeout_flag_n}));
    held = {pin_oe, pin_out};
    @(posedge core_clk);
    port_out <= ~port_out;
    port_oe <= ~port_oe;
    // Ineligible peripheral, late edge enable and global enable do not wake
    irq_src.timer_one_flag <= 1'b1;
    irq_src.timer_one_enable <= 1'b1;
    irq_src.ext_edge_flag <= 1'b1;
    irq_src.ext_edge_irq_enable <= 1'b1;
    global_irq_enable <= 1'b1;
    cyc(10);
    chk("pins held", held, {pin_oe, pin_out});
    chk("no wake", 16'h0001, 16'(core_halt));
    @(posedge core_clk);
    irq_src.timer_one_async <= 1'b1;
    await_pulse(1'b0, 10, n);
    chk("rc wake", 16'h0001, 16'(n < 10));
    chk("vector", 16'h0001, 16'(vec_seen));
    chk("vector addr", 16'h0004, 16'(vector_addr));
    // Watchdog wake from sleep, globals off
    @(posedge core_clk);
    irq_src <= '0;
    global_irq_enable <= 1'b0;
    pulse_cmd(1'b0); // Kick first: the short ratio must not fire on an old count
    wr(wdt_pkg::OPTION_ADDR, 8'h08);
    r0 = rst_cnt;
    pulse_cmd(1'b1);
    await_pulse(1'b0, 300, n);
    chk("watchdog wake", 16'h0001, 16'(n < 300 && rst_cnt == r0));
    chk("wake flags", 16'h0000, 16'({powerdown_flag_n, timeout_flag_n, vec_seen}));
    // Crystal mode: start-up wait after capture wake
    do_reset(14'h0004);
    wr(wdt_pkg::OPTION_ADDR, 8'h0f);
    pulse_cmd(1'b1);
    @(posedge core_clk);
    irq_src.capture_flag <= 1'b1;
    irq_src.capture_enable <= 1'b1;
    irq_src.capture_mode <= 1'b1;
    await_pulse(1'b0, 1200, n);
    chk("start wait", 16'h0001, 16'(n >= 1024 && n <= 1040));
    // Master clear while asleep resets the device
    @(posedge core_clk);
    irq_src <= '0;
    pulse_cmd(1'b1);
    @(posedge core_clk);
    master_clear_pin_n <= 1'b0;
    cyc(5);
    chk("clear pin reset", 16'h0001, 16'(device_reset));
    @(posedge core_clk);
    master_clear_pin_n <= 1'b1;
    cyc(5);
    rchk("clear pin status", wdt_pkg::STATUS_ADDR, 16'h0010);
    summarize();
  end
endmodule : watchdog_sleep_wake_tb_top

`default_nettype wire
